/* bod_pkg.sv */
/*
  Package for the brown-out detector control block: register offsets,
  field positions, action codes, timing counts and carrier structs.
  Assumes a plain byte-addressed register port with one-cycle strobes.
*/
package bod_pkg;

  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Byte offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IO_CTRL   = 8'h2C;
  localparam logic [ADDR_W-1:0] OFS_IO_LEVEL  = 8'h30;
  localparam logic [ADDR_W-1:0] OFS_IO_SAMP   = 8'h34;
  localparam logic [ADDR_W-1:0] OFS_CORE_CTRL = 8'h38;
  localparam logic [ADDR_W-1:0] OFS_CORE_LVL  = 8'h3C;
  localparam logic [ADDR_W-1:0] OFS_CORE_SAMP = 8'h40;
  localparam logic [ADDR_W-1:0] OFS_FLAGS     = 8'h48;

  // Control register fields
  localparam int CTRL_EN     = 0;
  localparam int CTRL_HYSTERESIS_ON   = 1;
  localparam int CTRL_ACT_LO = 8;
  localparam int CTRL_MODE   = 16;
  localparam int CTRL_FCD    = 31;
  localparam logic [1:0] ACT_NONE  = 2'h0;
  localparam logic [1:0] ACT_RESET = 2'h1;
  localparam logic [1:0] ACT_IRQ   = 2'h2;

  // Sampling register fields
  localparam int SAMP_CEN    = 0;
  localparam int SAMP_SAMPLE_CLOCK_SELECT  = 1;
  localparam int SAMP_PSL_LO = 8;
  localparam int LEVEL_W     = 6;
  localparam int PSEL_W      = 4;

  // Status register fields
  localparam int ST_CORE_FAIL = 0;
  localparam int ST_CORE_SYNC = 1;
  localparam int ST_IO_FAIL   = 2;
  localparam int ST_IO_SYNC   = 3;

  // Timing
  localparam int CLK_MHZ       = 100;
  localparam int SYSTEM_RC_OSCILLATOR_HALF_NS = 4000;
  localparam int MASK_EXTRA    = 2;
  localparam int MASK_CYC      = (SYSTEM_RC_OSCILLATOR_HALF_NS * CLK_MHZ + 999) / 1000
                                 + MASK_EXTRA;
  localparam int MASK_W        = 10;
  localparam int SYNC_CYC      = 3;
  localparam int SAMP_ON_CYC   = 4;
  localparam int CNT_W         = 17;

  typedef struct packed {
    logic                  fcd;
    logic                  mode;
    logic [1:0]            action;
    logic                  hysteresis_on;
    logic                  en;
  } bod_ctrl_t;

  typedef struct packed {
    logic [PSEL_W-1:0]     psel;
    logic                  sample_clock_select;
    logic                  sample_clock_gate;
  } bod_samp_t;

  typedef struct packed {
    logic                  fail;
    logic                  sync_ready;
    logic                  cen_seen;
    logic                  active;
    logic                  reset_req;
    logic                  irq_req;
    logic                  system_rc_oscillator_keep;
  } bod_stat_t;

  typedef struct packed {
    logic                  wr;
    logic                  rd;
    logic [ADDR_W-1:0]     addr;
    logic [DATA_W-1:0]     wdata;
  } bod_bus_t;

  function automatic logic [CNT_W-1:0] presc_top(input logic [PSEL_W-1:0] p);
    presc_top = CNT_W'((32'h0000_0002 << p) - 32'h0000_0001);
  endfunction

endpackage

/* bod_unit.sv */
/*
  One brown-out detector channel: enable masking, continuous or sampled
  monitoring, synchronised sampling configuration and action selection.
  Assumes the sampling clock and comparator arrive synchronous to clk.
*/
`timescale 1ns/1ps
module bod_unit
  import bod_pkg::*;
(
  input  wire logic             clk_in,
  input  wire logic             rstn_in,
  input  wire bod_ctrl_t        ctrl_in,
  input  wire bod_samp_t        samp_in,
  input  wire logic             samp_wr_in,
  input  wire logic             below_in,
  input  wire logic             system_rc_oscillator_tick_in,
  input  wire logic             k32_tick_in,
  input  wire logic             sleep_deep_in,
  output bod_samp_t             samp_out,
  output bod_stat_t             stat_out
);

  typedef struct packed {
    bod_samp_t                  samp;
    logic [MASK_W-1:0]          mask_cnt;
    logic                       en_d;
    logic [1:0]                 sync_cnt;
    logic [CNT_W-1:0]           presc;
    logic [2:0]                 on_cnt;
    bod_stat_t                  st;
  } bod_unit_state_t;

  bod_unit_state_t s, next_s;
  logic tick, sampling, live;

  always_comb begin
    next_s = s;
    tick = s.samp.sample_clock_gate & (s.samp.sample_clock_select ? k32_tick_in : system_rc_oscillator_tick_in);
    sampling = ctrl_in.mode;
    next_s.en_d = ctrl_in.en;
    if (ctrl_in.en & ~s.en_d) begin
      next_s.mask_cnt = MASK_W'(MASK_CYC); // see RQ3
    end else if (s.mask_cnt != '0) begin
      next_s.mask_cnt = s.mask_cnt - 1'b1;
    end
    if (samp_wr_in & s.st.sync_ready) begin
      next_s.samp = samp_in; // see RQ8
      next_s.sync_cnt = 2'(SYNC_CYC);
    end else if (s.sync_cnt != '0) begin
      next_s.sync_cnt = s.sync_cnt - 1'b1;
    end
    next_s.st.sync_ready = (next_s.sync_cnt == '0);
    // Readback follows the clock gate only once the crossing settled
    if (s.sync_cnt == 2'h1) begin
      next_s.st.cen_seen = s.samp.sample_clock_gate; // see RQ13
    end
    next_s.st.system_rc_oscillator_keep = s.samp.sample_clock_gate & ~s.samp.sample_clock_select; // see RQ10
    if (tick) begin
      if (s.presc == presc_top(s.samp.psel)) begin
        next_s.presc = '0;
        next_s.on_cnt = 3'(SAMP_ON_CYC); // see RQ6, RQ7
      end else begin
        next_s.presc = s.presc + 1'b1;
      end
    end
    if (s.on_cnt != '0) begin
      next_s.on_cnt = s.on_cnt - 1'b1;
    end
    // Continuous mode is off in deep sleep; sampling always runs
    live = ctrl_in.en & (sampling ? (s.on_cnt != '0) : ~sleep_deep_in);
    next_s.st.active = live; // see RQ5, RQ18
    if (live & (next_s.mask_cnt == '0)) begin
      next_s.st.fail = below_in; // see RQ1
    end else if (~ctrl_in.en) begin
      next_s.st.fail = 1'b0;
    end
    next_s.st.reset_req = next_s.st.fail & (ctrl_in.action == ACT_RESET);
    // In deep sleep the interrupt waits for wake-up
    next_s.st.irq_req = next_s.st.fail & (ctrl_in.action == ACT_IRQ)
                        & ~sleep_deep_in; // see RQ15, RQ19
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign samp_out = s.samp;
  assign stat_out = s.st;

  AST_MASK_HOLD: // see RQ3
    assert property (@(posedge clk_in) disable iff (!rstn_in)
    (ctrl_in.en & ~s.en_d) |=> !s.st.fail [*8])
    else $error("fail rose during enable mask");
  AST_SYNC_IGN: // see RQ8
    assert property (@(posedge clk_in) disable iff (!rstn_in)
    (samp_wr_in & ~s.st.sync_ready) |=> $stable(s.samp))
    else $error("sampling write taken while not ready");
  AST_RC_KEEP: // see RQ10
    assert property (@(posedge clk_in) disable iff (!rstn_in)
    (s.samp.sample_clock_gate & ~s.samp.sample_clock_select) |=> s.st.system_rc_oscillator_keep)
    else $error("rc oscillator not held");
  AST_CONT_OFF: // see RQ18
    assert property (@(posedge clk_in) disable iff (!rstn_in)
    (~ctrl_in.mode & sleep_deep_in) |=> !s.st.active)
    else $error("continuous detector active in deep sleep");
  AST_RST_ACT: // see RQ15
    assert property (@(posedge clk_in) disable iff (!rstn_in)
    s.st.reset_req |-> s.st.fail)
    else $error("reset without failure");
  AST_SYNC_BACK: // see RQ13
    assert property (@(posedge clk_in) disable iff (!rstn_in)
    (samp_wr_in & s.st.sync_ready) |=> !s.st.sync_ready [*3])
    else $error("sync ready too early");
  COV_SAMPLE: cover property (@(posedge clk_in) s.on_cnt == 3'h4);
  COV_FAIL: cover property (@(posedge clk_in) $rose(s.st.fail));
  COV_WR: cover property (@(posedge clk_in) samp_wr_in & s.st.sync_ready);

endmodule

/* bod_ctl.sv */
/*
  Top of the brown-out detector control: register port, two detector
  channels, status edge flags and fuse calibration at reset.
  Assumes comparator outputs and oscillator ticks synchronous to clk.
*/
//
// Contract
// RQ1: Each detector flags failure when its supply is below its level.
// RQ2: Detectors reset disabled; software or fuses may enable them.
// RQ3: After enable, mask output half an RC period plus two cycles.
// RQ4: Current detection result is readable in the status register.
// RQ5: Mode bit zero selects continuous monitoring, the default.
// RQ6: Mode bit one: briefly on at each sampling clock edge.
// RQ7: Sample rate is the source clock over two to PSEL plus one.
// RQ8: Sync-ready status exists; sampling writes ignored while it is zero.
// RQ9: Clock-gate bit gates sampling clock; select picks RC or 32k.
// RQ10: Selecting the RC oscillator keeps it enabled.
// RQ11: Software enables the 32k oscillator before selecting it.
// RQ12: Software disables the detector before stopping its clock.
// RQ13: Clock-gate readback changes only once the clock really changed.
// RQ14: Software waits for sync-ready before changing the prescaler.
// RQ15: Failure raises interrupt or reset as the action field selects.
// RQ16: Software writes action zero before selecting reset.
// RQ17: Hysteresis bit adds hysteresis to the trigger level.
// RQ18: Continuous mode off in deep sleep; sampling stays active.
// RQ19: Deep sleep sampling: reset immediate, interrupt delayed.
// RQ20: Calibration-done zero at reset reloads fuses and sets it.
// RQ21: Software may override fuse defaults by register writes.
// RQ22: Rise of a detection status bit sets its event flag.
// RQ23: Rise of a sync-ready bit sets its event flag.
// RQ24: Core and I/O detectors are identical independent instances.
`timescale 1ns/1ps
module bod_ctl
  import bod_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rstn_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  output logic [DATA_W-1:0]      rdata_out,
  input  wire logic              core_below_in,
  input  wire logic              io_below_in,
  input  wire logic              system_rc_oscillator_tick_in,
  input  wire logic              k32_tick_in,
  input  wire logic              sleep_deep_in,
  input  wire logic [15:0]       fuse_core_in,
  input  wire logic [15:0]       fuse_io_in,
  output logic                   bod_reset_out,
  output logic                   bod_irq_out,
  output logic                   system_rc_oscillator_keep_out,
  output logic [LEVEL_W-1:0]     core_level_out,
  output logic [LEVEL_W-1:0]     io_level_out,
  output logic                   core_hysteresis_on_out,
  output logic                   io_hysteresis_on_out,
  output logic                   core_active_out,
  output logic                   io_active_out
);

  typedef struct packed {
    logic                    cal_pend;
    bod_ctrl_t               core_ctrl;
    bod_ctrl_t               io_ctrl;
    logic [LEVEL_W-1:0]      core_level;
    logic [LEVEL_W-1:0]      io_level;
    logic [3:0]              flags;
    logic [3:0]              st_d;
    logic [DATA_W-1:0]       rdata;
    logic                    rst_o;
    logic                    irq_o;
    logic                    keep_o;
    logic                    core_act;
    logic                    io_act;
  } bod_top_state_t;

  bod_top_state_t s, next_s;
  bod_bus_t  bus;
  bod_samp_t core_samp, io_samp;
  bod_stat_t core_st, io_st;
  logic      core_samp_wr, io_samp_wr;
  logic [3:0] st_now;
  logic rstn_q;

  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_q);

  // Reset release through two flops; only the second copy is used
  logic [1:0] rsync;
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rsync <= 2'b00;
    end else begin
      rsync <= {rsync[0], 1'b1};
    end
  end
  assign rstn_q = rsync[1];

  function automatic bod_ctrl_t ctrl_from(input logic [DATA_W-1:0] d);
    ctrl_from.fcd    = d[CTRL_FCD];
    ctrl_from.mode   = d[CTRL_MODE];
    ctrl_from.action = d[CTRL_ACT_LO +: 2];
    ctrl_from.hysteresis_on   = d[CTRL_HYSTERESIS_ON];
    ctrl_from.en     = d[CTRL_EN];
  endfunction

  function automatic logic [DATA_W-1:0] ctrl_word(input bod_ctrl_t c);
    ctrl_word = '0;
    ctrl_word[CTRL_FCD]          = c.fcd;
    ctrl_word[CTRL_MODE]         = c.mode;
    ctrl_word[CTRL_ACT_LO +: 2]  = c.action;
    ctrl_word[CTRL_HYSTERESIS_ON]         = c.hysteresis_on;
    ctrl_word[CTRL_EN]           = c.en;
  endfunction

  function automatic logic [DATA_W-1:0] samp_word(input bod_samp_t p,
                                                   input logic cen_seen);
    samp_word = '0;
    samp_word[SAMP_PSL_LO +: PSEL_W] = p.psel;
    samp_word[SAMP_SAMPLE_CLOCK_SELECT]            = p.sample_clock_select;
    samp_word[SAMP_CEN]              = cen_seen;
  endfunction

  assign bus.wr    = wr_in;
  assign bus.rd    = rd_in;
  assign bus.addr  = addr_in;
  assign bus.wdata = wdata_in;

  assign core_samp_wr = bus.wr & (bus.addr == OFS_CORE_SAMP);
  assign io_samp_wr   = bus.wr & (bus.addr == OFS_IO_SAMP);

  // Detection and sync-ready, core pair in low bits
  assign st_now = {io_st.sync_ready, io_st.fail,
                   core_st.sync_ready, core_st.fail}; // see RQ4

  bod_samp_t samp_wdata;
  always_comb begin
    samp_wdata.psel  = bus.wdata[SAMP_PSL_LO +: PSEL_W];
    samp_wdata.sample_clock_select = bus.wdata[SAMP_SAMPLE_CLOCK_SELECT];
    samp_wdata.sample_clock_gate   = bus.wdata[SAMP_CEN]; // see RQ9
  end

  // Two identical channels keep the core and I/O paths independent
  bod_unit u_core (  // see RQ24
    .clk_in        (clk_in),
    .rstn_in       (rstn_q),
    .ctrl_in       (s.core_ctrl),
    .samp_in       (samp_wdata),
    .samp_wr_in    (core_samp_wr),
    .below_in      (core_below_in),
    .system_rc_oscillator_tick_in (system_rc_oscillator_tick_in),
    .k32_tick_in   (k32_tick_in),
    .sleep_deep_in (sleep_deep_in),
    .samp_out      (core_samp),
    .stat_out      (core_st)
  );

  bod_unit u_io (
    .clk_in        (clk_in),
    .rstn_in       (rstn_q),
    .ctrl_in       (s.io_ctrl),
    .samp_in       (samp_wdata),
    .samp_wr_in    (io_samp_wr),
    .below_in      (io_below_in),
    .system_rc_oscillator_tick_in (system_rc_oscillator_tick_in),
    .k32_tick_in   (k32_tick_in),
    .sleep_deep_in (sleep_deep_in),
    .samp_out      (io_samp),
    .stat_out      (io_st)
  );

  always_comb begin
    next_s = s;
    // Fuse load in the first cycle after release when not yet calibrated
    if (s.cal_pend) begin
      next_s.cal_pend = 1'b0;
      if (!s.core_ctrl.fcd) begin
        next_s.core_ctrl  = ctrl_from({16'h0000, fuse_core_in});
        next_s.core_ctrl.en     = fuse_core_in[CTRL_EN];
        next_s.core_ctrl.hysteresis_on   = fuse_core_in[CTRL_HYSTERESIS_ON];
        next_s.core_ctrl.action = fuse_core_in[CTRL_ACT_LO +: 2];
        next_s.core_level = fuse_core_in[LEVEL_W+1:2];
        next_s.core_ctrl.fcd = 1'b1; // see RQ2, RQ20
      end
      if (!s.io_ctrl.fcd) begin
        next_s.io_ctrl  = ctrl_from({16'h0000, fuse_io_in});
        next_s.io_ctrl.en     = fuse_io_in[CTRL_EN];
        next_s.io_ctrl.hysteresis_on   = fuse_io_in[CTRL_HYSTERESIS_ON];
        next_s.io_ctrl.action = fuse_io_in[CTRL_ACT_LO +: 2];
        next_s.io_level = fuse_io_in[LEVEL_W+1:2];
        next_s.io_ctrl.fcd = 1'b1; // see RQ20
      end
    end else if (bus.wr) begin
      if (bus.addr == OFS_CORE_CTRL) begin
        next_s.core_ctrl = ctrl_from(bus.wdata); // see RQ21
      end else if (bus.addr == OFS_IO_CTRL) begin
        next_s.io_ctrl = ctrl_from(bus.wdata);
      end else if (bus.addr == OFS_CORE_LVL) begin
        next_s.core_level = bus.wdata[LEVEL_W-1:0];
      end else if (bus.addr == OFS_IO_LEVEL) begin
        next_s.io_level = bus.wdata[LEVEL_W-1:0];
      end
    end
    // Write-one clears; a new rising edge wins over the clear
    if (bus.wr & (bus.addr == OFS_FLAGS)) begin
      next_s.flags = s.flags & ~bus.wdata[3:0];
    end
    next_s.st_d  = st_now;
    next_s.flags = next_s.flags | (st_now & ~s.st_d); // see RQ22, RQ23
    next_s.rdata = '0;
    if (bus.rd) begin
      if (bus.addr == OFS_STATUS) begin
        next_s.rdata = {28'h000_0000, st_now};
      end else if (bus.addr == OFS_CORE_CTRL) begin
        next_s.rdata = ctrl_word(s.core_ctrl);
      end else if (bus.addr == OFS_IO_CTRL) begin
        next_s.rdata = ctrl_word(s.io_ctrl);
      end else if (bus.addr == OFS_CORE_LVL) begin
        next_s.rdata = {26'h000_0000, s.core_level};
      end else if (bus.addr == OFS_IO_LEVEL) begin
        next_s.rdata = {26'h000_0000, s.io_level};
      end else if (bus.addr == OFS_CORE_SAMP) begin
        next_s.rdata = samp_word(core_samp, core_st.cen_seen); // see RQ13
      end else if (bus.addr == OFS_IO_SAMP) begin
        next_s.rdata = samp_word(io_samp, io_st.cen_seen);
      end else if (bus.addr == OFS_FLAGS) begin
        next_s.rdata = {28'h000_0000, s.flags};
      end
    end
    next_s.rst_o    = core_st.reset_req | io_st.reset_req; // see RQ15
    next_s.irq_o    = core_st.irq_req | io_st.irq_req;     // see RQ19
    next_s.keep_o   = core_st.system_rc_oscillator_keep | io_st.system_rc_oscillator_keep; // see RQ10
    next_s.core_act = core_st.active;
    next_s.io_act   = io_st.active;
  end

  always_ff @(posedge clk_in or negedge rstn_q) begin
    if (!rstn_q) begin
      s <= '0;
      s.cal_pend <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rdata_out       = s.rdata;
  assign bod_reset_out   = s.rst_o;
  assign bod_irq_out     = s.irq_o;
  assign system_rc_oscillator_keep_out  = s.keep_o;
  assign core_level_out  = s.core_level;  // see RQ1
  assign io_level_out    = s.io_level;
  assign core_hysteresis_on_out   = s.core_ctrl.hysteresis_on; // see RQ17
  assign io_hysteresis_on_out     = s.io_ctrl.hysteresis_on;
  assign core_active_out = s.core_act;
  assign io_active_out   = s.io_act;

  AST_EDGE_FLAG: // see RQ22
    assert property ((st_now[0] & ~s.st_d[0]) |=> s.flags[0])
    else $error("core detection edge flag missed");

  AST_SYNC_FLAG: // see RQ23
    assert property ((st_now[3] & ~s.st_d[3]) |=> s.flags[3])
    else $error("io sync edge flag missed");

  AST_FCD_SET: // see RQ20
    assert property (s.cal_pend |=> (s.core_ctrl.fcd & s.io_ctrl.fcd))
    else $error("calibration done not set");

  AST_CAL_ONCE: // see RQ20
    assert property (!s.cal_pend |=> !s.cal_pend)
    else $error("fuse load repeated");

  AST_RD_IDLE: // see RQ4
    assert property (!bus.rd |=> (s.rdata == '0))
    else $error("read data not cleared");

  AST_RD_STAT: // see RQ4
    assert property ((bus.rd & (bus.addr == OFS_STATUS))
      |=> (s.rdata[3:0] == $past(st_now)))
    else $error("status read wrong");

  AST_FLAG_CLR: // see RQ22
    assert property ((bus.wr & (bus.addr == OFS_FLAGS) & bus.wdata[0]
      & ~st_now[0]) |=> !s.flags[0])
    else $error("event flag not cleared");

  AST_FLAG_HOLD: // see RQ22
    assert property ((s.flags[2] & ~(bus.wr & (bus.addr == OFS_FLAGS)))
      |=> s.flags[2])
    else $error("event flag lost");

  AST_CTRL_WR: // see RQ2
    assert property ((bus.wr & (bus.addr == OFS_CORE_CTRL) & ~s.cal_pend)
      |=> (s.core_ctrl.en == $past(bus.wdata[CTRL_EN])))
    else $error("enable write lost");

  AST_LVL_WR: // see RQ21
    assert property ((bus.wr & (bus.addr == OFS_CORE_LVL) & ~s.cal_pend)
      |=> (s.core_level == $past(bus.wdata[LEVEL_W-1:0])))
    else $error("level write lost");

  AST_IRQ_SLEEP: // see RQ19
    assert property (sleep_deep_in |-> ##2 !s.irq_o)
    else $error("interrupt during deep sleep");

  AST_KEEP_OUT: // see RQ10
    assert property ((core_samp.sample_clock_gate & ~core_samp.sample_clock_select) |-> ##2 s.keep_o)
    else $error("rc oscillator keep missing");

  COV_RST: cover property (@(posedge clk_in) $rose(s.rst_o));
  COV_IRQ: cover property ($rose(s.irq_o));

endmodule

/* bod_ctl_tb_top.sv */
/*
  Self-checking bench for bod_ctl: fuse load, enable mask, actions,
  sampling rate, synchroniser refusal and sampling clock source change.
  Assumes the register map, field positions and timing of bod_pkg.
*/
`timescale 1ns/1ps
module bod_ctl_tb_top
  import bod_pkg::*;
();
  logic                clk_in;
  logic                rstn_in;
  logic                wr_in;
  logic                rd_in;
  logic [ADDR_W-1:0]   addr_in;
  logic [DATA_W-1:0]   wdata_in;
  logic [DATA_W-1:0]   rdata_out;
  logic                core_below_in;
  logic                io_below_in;
  logic                system_rc_oscillator_tick_in = 1'b0;
  logic                k32_tick_in   = 1'b0;
  logic                sleep_deep_in;
  logic [15:0]         fuse_core_in;
  logic [15:0]         fuse_io_in;
  logic                bod_reset_out;
  logic                bod_irq_out;
  logic                system_rc_oscillator_keep_out;
  logic [LEVEL_W-1:0]  core_level_out;
  logic [LEVEL_W-1:0]  io_level_out;
  logic                core_hysteresis_on_out;
  logic                io_hysteresis_on_out;
  logic                core_active_out;
  logic                io_active_out;
  logic [7:0]          tcnt          = 8'h00;
  int                  num_errors    = 0;
  int                  num_checks    = 0;

  bod_ctl bod_ctl_inst (
    .clk_in          (clk_in),
    .rstn_in         (rstn_in),
    .wr_in           (wr_in),
    .rd_in           (rd_in),
    .addr_in         (addr_in),
    .wdata_in        (wdata_in),
    .rdata_out       (rdata_out),
    .core_below_in   (core_below_in),
    .io_below_in     (io_below_in),
    .system_rc_oscillator_tick_in   (system_rc_oscillator_tick_in),
    .k32_tick_in     (k32_tick_in),
    .sleep_deep_in   (sleep_deep_in),
    .fuse_core_in    (fuse_core_in),
    .fuse_io_in      (fuse_io_in),
    .bod_reset_out   (bod_reset_out),
    .bod_irq_out     (bod_irq_out),
    .system_rc_oscillator_keep_out  (system_rc_oscillator_keep_out),
    .core_level_out  (core_level_out),
    .io_level_out    (io_level_out),
    .core_hysteresis_on_out   (core_hysteresis_on_out),
    .io_hysteresis_on_out     (io_hysteresis_on_out),
    .core_active_out (core_active_out),
    .io_active_out   (io_active_out)
  );

  initial begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Ticks run free; RC edges every 8 cycles, 32k edges every 16
  always @(posedge clk_in) begin
    tcnt <= tcnt + 8'h01;
    system_rc_oscillator_tick_in <= (tcnt[2:0] == 3'h0);
    k32_tick_in <= (tcnt[3:0] == 4'h3);
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic reg_wr(input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wdata_in <= d;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [ADDR_W-1:0] a,
                        output logic [DATA_W-1:0] d);
    @(posedge clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1;
    d = rdata_out;
  endtask

  task automatic wait_bit(input logic [ADDR_W-1:0] a, input int b,
                          input logic v, output logic got);
    logic [DATA_W-1:0] d;
    for (int i = 0; i < 50; i++) begin
      reg_rd(a, d);
      if (d[b] === v) break;
    end
    got = d[b];
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask

  // Ticks of the chosen source between two rises of io_active_out
  task automatic measure(input logic k32, output int ticks);
    int   n;
    int   rises;
    logic prev;
    ticks = 0;
    rises = 0;
    n = 0;
    prev = io_active_out;
    while (rises < 2 && n < 2000) begin
      @(posedge clk_in);
      #1;
      if (rises == 1 && (k32 ? k32_tick_in : system_rc_oscillator_tick_in)) ticks++;
      if (io_active_out === 1'b1 && prev === 1'b0) rises++;
      prev = io_active_out;
      n++;
    end
  endtask

  task automatic test_fuse;
    logic [DATA_W-1:0] d;
    reg_rd(OFS_CORE_CTRL, d);
    check(d, 32'h8000_0002);
    reg_rd(OFS_CORE_LVL, d);
    check(d, 32'h0000_0015);
    reg_rd(OFS_IO_CTRL, d);
    check(d, 32'h8000_0201);
    check(32'(core_active_out), 32'h0000_0000);
    check(32'(core_hysteresis_on_out), 32'h0000_0001);
    check(32'(io_level_out), 32'h0000_000A);
    check(32'(io_hysteresis_on_out), 32'h0000_0000);
    check(32'(io_active_out), 32'h0000_0001);
    reg_rd(8'h04, d);
    check(d, 32'h0000_0000);
  endtask

  task automatic test_enable;
    logic [DATA_W-1:0] d;
    int                n;
    core_below_in <= 1'b1;
    reg_wr(OFS_CORE_CTRL, 32'h0000_0000);
    reg_wr(OFS_CORE_CTRL, 32'h0000_0103);
    n = 0;
    while (bod_reset_out !== 1'b1 && n < MASK_CYC + 50) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check(32'(n >= MASK_CYC - 4 && n <= MASK_CYC + 6), 32'h1);
    check(32'(core_hysteresis_on_out), 32'h0000_0001);
    reg_rd(OFS_STATUS, d);
    check(32'(d[ST_CORE_FAIL]), 32'h0000_0001);
    check(32'(d[ST_IO_FAIL]), 32'h0000_0000);
    reg_rd(OFS_FLAGS, d);
    check(32'(d[ST_CORE_FAIL]), 32'h0000_0001);
    reg_wr(OFS_FLAGS, 32'h0000_0001);
    reg_rd(OFS_FLAGS, d);
    check(32'(d[ST_CORE_FAIL]), 32'h0000_0000);
    core_below_in <= 1'b0;
    wait_cyc(8);
    check(32'(bod_reset_out), 32'h0000_0000);
    reg_wr(OFS_CORE_LVL, 32'h0000_003F);
    wait_cyc(2);
    check(32'(core_level_out), 32'h0000_003F);
    check(32'(io_level_out), 32'h0000_000A);
  endtask

  task automatic test_irq;
    io_below_in <= 1'b1;
    wait_cyc(6);
    check(32'(bod_irq_out), 32'h0000_0001);
    check(32'(bod_reset_out), 32'h0000_0000);
    sleep_deep_in <= 1'b1;
    wait_cyc(6);
    check(32'(io_active_out), 32'h0000_0000);
    check(32'(bod_irq_out), 32'h0000_0000);
    sleep_deep_in <= 1'b0;
    io_below_in <= 1'b0;
    wait_cyc(6);
  endtask

  task automatic test_sampling;
    logic [DATA_W-1:0] d;
    logic              got;
    int                t;
    wait_bit(OFS_STATUS, ST_IO_SYNC, 1'b1, got);
    check(32'(got), 32'h0000_0001);
    reg_wr(OFS_FLAGS, 32'h0000_000F);
    // Second write lands while the synchroniser is busy
    @(posedge clk_in);
    wr_in <= 1'b1;
    addr_in <= OFS_IO_SAMP;
    wdata_in <= 32'h0000_0001;
    @(posedge clk_in);
    wdata_in <= 32'h0000_0301;
    @(posedge clk_in);
    wr_in <= 1'b0;
    wait_bit(OFS_IO_SAMP, SAMP_CEN, 1'b1, got);
    check(32'(got), 32'h0000_0001);
    wait_bit(OFS_STATUS, ST_IO_SYNC, 1'b1, got);
    reg_rd(OFS_IO_SAMP, d);
    check(32'(d[11:8]), 32'h0000_0000);
    reg_rd(OFS_FLAGS, d);
    check(32'(d[ST_IO_SYNC]), 32'h0000_0001);
    check(32'(system_rc_oscillator_keep_out), 32'h0000_0001);
    reg_wr(OFS_IO_CTRL, 32'h0001_0201);
    measure(1'b0, t);
    check(32'(t), 32'h0000_0002);
    reg_wr(OFS_IO_SAMP, 32'h0000_0101);
    wait_bit(OFS_STATUS, ST_IO_SYNC, 1'b1, got);
    measure(1'b0, t);
    check(32'(t), 32'h0000_0004);
    sleep_deep_in <= 1'b1;
    io_below_in <= 1'b1;
    measure(1'b0, t);
    check(32'(t), 32'h0000_0004);
    check(32'(bod_irq_out), 32'h0000_0000);
    sleep_deep_in <= 1'b0;
    wait_cyc(6);
    check(32'(bod_irq_out), 32'h0000_0001);
    io_below_in <= 1'b0;
    reg_wr(OFS_IO_CTRL, 32'h0001_0200);
    reg_wr(OFS_IO_SAMP, 32'h0000_0100);
    wait_bit(OFS_IO_SAMP, SAMP_CEN, 1'b0, got);
    check(32'(got), 32'h0000_0000);
    wait_bit(OFS_STATUS, ST_IO_SYNC, 1'b1, got);
    reg_wr(OFS_IO_SAMP, 32'h0000_0102);
    wait_bit(OFS_STATUS, ST_IO_SYNC, 1'b1, got);
    reg_wr(OFS_IO_SAMP, 32'h0000_0103);
    wait_bit(OFS_IO_SAMP, SAMP_CEN, 1'b1, got);
    check(32'(got), 32'h0000_0001);
    reg_wr(OFS_IO_CTRL, 32'h0001_0201);
    check(32'(system_rc_oscillator_keep_out), 32'h0000_0000);
    measure(1'b1, t);
    check(32'(t), 32'h0000_0004);
    wait_bit(OFS_STATUS, ST_IO_SYNC, 1'b1, got);
    reg_wr(OFS_IO_CTRL, 32'h0001_0200);
    reg_wr(OFS_IO_SAMP, 32'h0000_0102);
    wait_bit(OFS_IO_SAMP, SAMP_CEN, 1'b0, got);
    reg_wr(OFS_IO_CTRL, 32'h0001_0201);
    measure(1'b1, t);
    check(32'(t), 32'h0000_0000);
  endtask

  // Whole run needs well under 20000 cycles
  initial begin
    #500_000;
    num_errors++;
    report_and_stop();
  end

  initial begin
    rstn_in = 1'b0;
    wr_in = 1'b0;
    rd_in = 1'b0;
    addr_in = 8'h00;
    wdata_in = 32'h0000_0000;
    core_below_in = 1'b0;
    io_below_in = 1'b0;
    sleep_deep_in = 1'b0;
    fuse_core_in = 16'h0056;
    fuse_io_in = 16'h0229;
    repeat (4) @(posedge clk_in);
    rstn_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    test_fuse();
    test_enable();
    test_irq();
    test_sampling();
    report_and_stop();
  end
endmodule
